// [common/plpb_consts.svh]
// Constants of the loopback, PRBS self-test and cable diagnostic block.
// Assumes inclusion by bare name; holds definitions only.
`ifndef PLPB_CONSTS_SVH
`define PLPB_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PLPB_ADDR_BMC 5'h00
`define PLPB_ADDR_GC1 5'h09
`define PLPB_ADDR_STC 5'h16
`define PLPB_ADDR_ERRC 5'h1b
`define PLPB_ADDR_PLEN 5'h1c
`define PLPB_ADDR_TDRS 5'h1d
`define PLPB_ADDR_TDRR 5'h1e
`define PLPB_ADDR_ALEN 5'h1f

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PLPB_BMC_MAC_LOOP 14
`define PLPB_GC1_TDR_AUTO 8
`define PLPB_STC_PCS_IN 0
`define PLPB_STC_PCS_OUT 1
`define PLPB_STC_DIG 2
`define PLPB_STC_ANA 3
`define PLPB_STC_FAR 4
`define PLPB_STC_GEN_EN 5
`define PLPB_STC_LOOP_TX 6
`define PLPB_STC_LOCK 8
`define PLPB_STC_SYNC_LOST 9
`define PLPB_STC_BUSY 10
`define PLPB_STC_ONE_SIZE 12
`define PLPB_STC_ONE_GO 13
`define PLPB_STC_CNT_MODE 14
`define PLPB_TDRS_START 0
`define PLPB_TDRS_BUSY 1

// ----------------------------------------
// Reset values and fixed figures
// ----------------------------------------
`define PLPB_RST_CTRL 16'h0000
`define PLPB_RST_PLEN 16'h0040
`define PLPB_IPG_BYTES 11'h00c
`define PLPB_ONE_SHORT 11'h040
`define PLPB_ONE_LONG 11'h5ee
`define PLPB_ONE_DATA 8'h5a
`define PLPB_PRBS_SEED 15'h7fff
`define PLPB_LOCK_GOOD 4'hf
`define PLPB_LOSE_BAD 4'h8
`define PLPB_TDR_SLOTS 3'h5
`define PLPB_TDR_CROSS_SLOTS 3'h4

// ----------------------------------------
// Timing
// ----------------------------------------
`define PLPB_CLK_NS 5
`define PLPB_NIB_100_NS 40
`define PLPB_NIB_10_NS 400
`define PLPB_NIB_100_CYC (`PLPB_NIB_100_NS / `PLPB_CLK_NS)
`define PLPB_NIB_10_CYC (`PLPB_NIB_10_NS / `PLPB_CLK_NS)

`endif

// [common/plpb_pkg.sv]
// Types used by the loopback and self-test block; its FIFO takes plain vectors.
// Assumes a SystemVerilog compiler; holds no logic.
package plpb_pkg;

  // One nibble slot of a data stream: frame enable and data
  typedef struct packed {
    logic en;
    logic [3:0] d;
  } plpb_nib_t;

  // Packet generator states
  typedef enum logic [2:0] {
    PLPB_GEN_IDLE = 3'b001,
    PLPB_GEN_DATA = 3'b010,
    PLPB_GEN_GAP = 3'b100
  } plpb_gen_state_t;

endpackage

// [rtl/plpb_fifo.sv]
// Small synchronous FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module plpb_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Full and empty come from the count, so both flags are honest
  assign in_ready = (count_reg != (AW + 1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];

  // Pointers wrap by modulo, DEPTH is a power of two
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      count_reg <= count_reg + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

  // Storage has no reset; reads are guarded by out_valid
  always_ff @(posedge core_clk) begin
    if (push) mem[wr_ptr_reg] <= in_data;
  end
endmodule

// [rtl/plpb_top.sv]
// Loopback selection, PRBS generator and checker, reflectometry capture and
// passive cable length capture, behind a small management register port.
// Assumes nibble-wide MAC and line streams synchronous to core_clk, and an
// analog front end that reports reflections and equaliser metrics as pulses.
`timescale 1ns/1ps
`include "plpb_consts.svh"
module plpb_top (
  input wire logic core_clk,
  input wire logic reset_n,
  // Management register port
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Operating mode
  input wire logic speed_100,
  input wire logic rmii_mode,
  input wire logic aneg_on,
  input wire logic link_up,
  output logic link_ok,
  // MAC side
  input wire logic mac_tx_en,
  input wire logic [3:0] mac_txd,
  output logic mac_tx_ready,
  output logic mac_rx_dv,
  output logic [3:0] mac_rxd,
  // Line side
  input wire logic line_rx_dv,
  input wire logic [3:0] line_rxd,
  output logic line_tx_en,
  output logic [3:0] line_txd,
  input wire logic line_tx_ready,
  // Reflectometry front end
  output logic tdr_start,
  input wire logic tdr_done,
  input wire logic tdr_refl_valid,
  input wire logic tdr_refl_cross,
  input wire logic [11:0] tdr_refl_time,
  // Receive equaliser metric for length estimate
  input wire logic alen_valid,
  input wire logic [7:0] alen_metric
);

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  logic [15:0] bmc_reg;
  logic [15:0] gc1_reg;
  logic [15:0] stc_reg;
  logic [15:0] errc_reg;
  logic [15:0] plen_reg;
  logic [7:0] alen_reg;
  logic [2:0] tdr_sel_reg;
  logic sync_lost_reg;
  logic lock_reg;
  logic [6:0] div_reg;
  logic nib_en_reg;
  plpb_pkg::plpb_nib_t stage_reg [4];
  plpb_pkg::plpb_gen_state_t gen_state_reg;
  logic [14:0] gen_lfsr_reg;
  logic [10:0] gen_cnt_reg;
  logic gen_half_reg;
  logic gen_one_reg;
  logic gen_long_reg;
  logic [14:0] chk_hist_reg;
  logic [3:0] good_cnt_reg;
  logic [3:0] bad_cnt_reg;
  logic chk_half_reg;
  logic chk_err_reg;
  logic link_d_reg;
  logic tdr_busy_reg;
  logic [2:0] tdr_cnt_reg;
  logic tdr_cross_reg;
  logic [11:0] tdr_cross_loc_reg;
  logic [11:0] tdr_time_mem [5];

  // ----------------------------------------
  // Register port decode
  // ----------------------------------------
  wire wr_bmc = reg_wr && (reg_addr == `PLPB_ADDR_BMC);
  wire wr_gc1 = reg_wr && (reg_addr == `PLPB_ADDR_GC1);
  wire wr_stc = reg_wr && (reg_addr == `PLPB_ADDR_STC);
  wire wr_plen = reg_wr && (reg_addr == `PLPB_ADDR_PLEN);
  wire wr_tdrs = reg_wr && (reg_addr == `PLPB_ADDR_TDRS);
  wire wr_tdrr = reg_wr && (reg_addr == `PLPB_ADDR_TDRR);
  wire rd_errc = reg_rd && (reg_addr == `PLPB_ADDR_ERRC);

  // ----------------------------------------
  // Loopback selection
  // ----------------------------------------
  // Each point is honoured only in the modes where it works
  wire forced_100 = speed_100 && !aneg_on;
  wire lb_mac = bmc_reg[`PLPB_BMC_MAC_LOOP] && !rmii_mode;
  wire lb_pin = stc_reg[`PLPB_STC_PCS_IN] && !aneg_on;
  wire lb_pout = stc_reg[`PLPB_STC_PCS_OUT] && forced_100;
  wire lb_dig = stc_reg[`PLPB_STC_DIG] && forced_100;
  wire lb_ana = stc_reg[`PLPB_STC_ANA] && (!aneg_on || !speed_100);
  wire lb_far = stc_reg[`PLPB_STC_FAR] && (!rmii_mode || !speed_100);
  wire lb_near = lb_pin || lb_pout || lb_dig || lb_ana;
  wire mac_loop_tx = stc_reg[`PLPB_STC_LOOP_TX] && speed_100;
  // Line transmit is muted for internal loops; MAC loop sends only when asked
  wire line_send = !lb_near && (!lb_mac || mac_loop_tx);

  // ----------------------------------------
  // Nibble rate divider
  // ----------------------------------------
  wire [6:0] div_last = speed_100 ? 7'(`PLPB_NIB_100_CYC - 1) : 7'(`PLPB_NIB_10_CYC - 1);
  always_ff @(posedge core_clk) begin
    if (!reset_n || div_reg >= div_last) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 7'h01;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!reset_n) nib_en_reg <= 1'b0;
    else nib_en_reg <= (div_reg == div_last);
  end

  // ----------------------------------------
  // PRBS step functions
  // ----------------------------------------
  // Generator: x^15 + x^14 + 1, four bits per nibble, LSB first
  function automatic logic [18:0] prbs_gen(input logic [14:0] s);
    logic [14:0] l;
    logic [3:0] n;
    l = s;
    n = '0;
    for (int i = 0; i < 4; i++) begin
      n[i] = l[14] ^ l[13];
      l = {l[13:0], n[i]};
    end
    return {l, n};
  endfunction

  // Checker is self-synchronising: it predicts each bit from received history
  function automatic logic [15:0] prbs_chk(input logic [14:0] h, input logic [3:0] n);
    logic [14:0] l;
    logic e;
    l = h;
    e = 1'b0;
    for (int i = 0; i < 4; i++) begin
      e = e | ((l[14] ^ l[13]) != n[i]);
      l = {l[13:0], n[i]};
    end
    return {e, l};
  endfunction

  // ----------------------------------------
  // Packet generator
  // ----------------------------------------
  logic fifo_in_ready;
  wire gen_step = nib_en_reg && fifo_in_ready;
  wire [18:0] gen_nx = prbs_gen(gen_lfsr_reg);
  wire gen_go = stc_reg[`PLPB_STC_GEN_EN] || gen_one_reg;
  // Single packet length and data are fixed; otherwise length comes from software
  wire [10:0] gen_len = gen_one_reg ? (gen_long_reg ? `PLPB_ONE_LONG : `PLPB_ONE_SHORT)
                                    : plen_reg[10:0];
  wire [7:0] one_byte = `PLPB_ONE_DATA;
  wire [3:0] one_nib = gen_half_reg ? one_byte[7:4] : one_byte[3:0];
  wire gen_active = (gen_state_reg == plpb_pkg::PLPB_GEN_DATA);
  wire gen_busy = (gen_state_reg != plpb_pkg::PLPB_GEN_IDLE);
  wire gen_byte_end = gen_half_reg && gen_step;
  wire gen_last = gen_byte_end && (gen_cnt_reg + 11'h001 >= gen_len);

  // Packets of PRBS data, or of fixed data for a single packet, each followed by an inter-packet gap
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      gen_state_reg <= plpb_pkg::PLPB_GEN_IDLE;
      gen_cnt_reg <= '0;
      gen_half_reg <= 1'b0;
    end else begin
      unique case (gen_state_reg)
        plpb_pkg::PLPB_GEN_IDLE: begin
          gen_cnt_reg <= '0;
          gen_half_reg <= 1'b0;
          if (gen_go && gen_len != '0) gen_state_reg <= plpb_pkg::PLPB_GEN_DATA;
        end
        plpb_pkg::PLPB_GEN_DATA: begin
          if (gen_step) gen_half_reg <= !gen_half_reg;
          if (gen_byte_end) gen_cnt_reg <= gen_cnt_reg + 11'h001;
          if (gen_last) begin
            gen_cnt_reg <= '0;
            gen_state_reg <= plpb_pkg::PLPB_GEN_GAP;
          end
        end
        plpb_pkg::PLPB_GEN_GAP: begin
          if (gen_step) gen_half_reg <= !gen_half_reg;
          if (gen_byte_end) gen_cnt_reg <= gen_cnt_reg + 11'h001;
          if (gen_byte_end && gen_cnt_reg + 11'h001 >= `PLPB_IPG_BYTES) begin
            gen_state_reg <= plpb_pkg::PLPB_GEN_IDLE;
          end
        end
      endcase
    end
  end

  // Sequence runs on across packets so the stream is continuous
  always_ff @(posedge core_clk) begin
    if (!reset_n) gen_lfsr_reg <= `PLPB_PRBS_SEED;
    else if (gen_active && gen_step && !gen_one_reg) gen_lfsr_reg <= gen_nx[18:4];
  end

  // Single packet request is held until its gap ends
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      gen_one_reg <= 1'b0;
      gen_long_reg <= 1'b0;
    end else if (wr_stc && reg_wdata[`PLPB_STC_ONE_GO] && !gen_busy) begin
      gen_one_reg <= 1'b1;
      gen_long_reg <= reg_wdata[`PLPB_STC_ONE_SIZE];
    end else if (gen_state_reg == plpb_pkg::PLPB_GEN_GAP && gen_byte_end
                 && gen_cnt_reg + 11'h001 >= `PLPB_IPG_BYTES) begin
      gen_one_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Transmit path and near-end loop stages
  // ----------------------------------------
  plpb_pkg::plpb_nib_t tx_in;
  plpb_pkg::plpb_nib_t line_in;
  plpb_pkg::plpb_nib_t mac_in;
  plpb_pkg::plpb_nib_t gen_nib;
  assign line_in = '{en: line_rx_dv, d: line_rxd};
  assign mac_in = '{en: mac_tx_en, d: mac_txd};
  assign gen_nib = '{en: gen_active, d: gen_one_reg ? one_nib : gen_nx[3:0]};
  // Far-end loop ignores the MAC and returns the line stream
  assign tx_in = gen_busy ? gen_nib : (lb_far ? line_in : mac_in);

  // Each deeper loop point adds one nibble of delay
  for (genvar k = 0; k < 4; k++) begin : g_stage
    always_ff @(posedge core_clk) begin
      if (!reset_n) stage_reg[k] <= '0;
      else if (nib_en_reg) stage_reg[k] <= (k == 0) ? tx_in : stage_reg[(k == 0) ? 0 : k - 1];
    end
  end

  // ----------------------------------------
  // Receive path selection
  // ----------------------------------------
  plpb_pkg::plpb_nib_t near_tap;
  plpb_pkg::plpb_nib_t rx_path;
  assign near_tap = lb_pin ? stage_reg[0] : lb_pout ? stage_reg[1]
                  : lb_dig ? stage_reg[2] : stage_reg[3];
  assign rx_path = lb_mac ? mac_in : (lb_near ? near_tap : line_in);

  // Outputs toward the MAC and link indication
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      mac_rx_dv <= 1'b0;
      mac_rxd <= '0;
      link_ok <= 1'b0;
    end else begin
      mac_rx_dv <= rx_path.en;
      mac_rxd <= rx_path.d;
      link_ok <= link_up && !lb_mac;
    end
  end

  // ----------------------------------------
  // Line transmit FIFO
  // ----------------------------------------
  plpb_pkg::plpb_nib_t fifo_in;
  plpb_pkg::plpb_nib_t fifo_out;
  logic fifo_out_valid;
  assign fifo_in = '{en: tx_in.en && line_send, d: tx_in.d};
  plpb_fifo #(.WIDTH(5), .DEPTH(8)) u_tx_fifo (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .in_valid(nib_en_reg),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(line_tx_ready),
    .out_data(fifo_out)
  );

  // Line outputs hold each nibble until the next one is drained
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      line_tx_en <= 1'b0;
      line_txd <= '0;
      mac_tx_ready <= 1'b0;
    end else begin
      mac_tx_ready <= fifo_in_ready;
      if (fifo_out_valid && line_tx_ready) begin
        line_tx_en <= fifo_out.en;
        line_txd <= fifo_out.d;
      end
    end
  end

  // ----------------------------------------
  // PRBS checker
  // ----------------------------------------
  wire chk_step = nib_en_reg && rx_path.en;
  wire [15:0] chk_nx = prbs_chk(chk_hist_reg, rx_path.d);
  wire byte_bad = chk_half_reg && (chk_err_reg || chk_nx[15]);
  wire count_err = chk_step && lock_reg && byte_bad;
  wire err_max = (errc_reg == 16'hffff);
  wire err_hold = err_max && stc_reg[`PLPB_STC_CNT_MODE];
  wire lose_sync = chk_step && lock_reg && chk_nx[15] && (bad_cnt_reg == `PLPB_LOSE_BAD - 4'h1);

  // Lock after a run of good nibbles, lose it after a run of bad ones
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      chk_hist_reg <= '0;
      good_cnt_reg <= '0;
      bad_cnt_reg <= '0;
      lock_reg <= 1'b0;
    end else if (chk_step) begin
      chk_hist_reg <= chk_nx[14:0];
      good_cnt_reg <= chk_nx[15] ? 4'h0 : good_cnt_reg + {3'h0, !(&good_cnt_reg)};
      bad_cnt_reg <= chk_nx[15] ? bad_cnt_reg + 4'h1 : 4'h0;
      if (!lock_reg && good_cnt_reg == `PLPB_LOCK_GOOD) lock_reg <= 1'b1;
      else if (lose_sync) lock_reg <= 1'b0;
    end
  end

  // Byte framing restarts with every received frame
  always_ff @(posedge core_clk) begin
    if (!reset_n || !rx_path.en) begin
      chk_half_reg <= 1'b0;
      chk_err_reg <= 1'b0;
    end else if (chk_step) begin
      chk_half_reg <= !chk_half_reg;
      chk_err_reg <= chk_half_reg ? 1'b0 : chk_nx[15];
    end
  end

  // Error byte counter clears on read; a new error in that cycle still counts
  always_ff @(posedge core_clk) begin
    if (!reset_n) errc_reg <= '0;
    else if (rd_errc) errc_reg <= {15'h0000, count_err};
    else if (count_err && !err_hold) errc_reg <= errc_reg + 16'h0001;
  end

  // Sync loss is sticky, cleared by a write of one; the set wins
  always_ff @(posedge core_clk) begin
    if (!reset_n) sync_lost_reg <= 1'b0;
    else if (lose_sync) sync_lost_reg <= 1'b1;
    else if (wr_stc && reg_wdata[`PLPB_STC_SYNC_LOST]) sync_lost_reg <= 1'b0;
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      bmc_reg <= `PLPB_RST_CTRL;
      gc1_reg <= `PLPB_RST_CTRL;
      stc_reg <= `PLPB_RST_CTRL;
      plen_reg <= `PLPB_RST_PLEN;
      tdr_sel_reg <= '0;
    end else begin
      if (wr_bmc) bmc_reg <= reg_wdata;
      if (wr_gc1) gc1_reg <= reg_wdata;
      if (wr_stc) stc_reg <= reg_wdata & 16'h40ff; // Status and trigger bits not stored
      if (wr_plen) plen_reg <= reg_wdata;
      if (wr_tdrr) tdr_sel_reg <= reg_wdata[2:0];
    end
  end

  // ----------------------------------------
  // Reflectometry control and capture
  // ----------------------------------------
  wire link_fall = link_d_reg && !link_up;
  wire tdr_auto = link_fall && gc1_reg[`PLPB_GC1_TDR_AUTO];
  wire tdr_go = !tdr_busy_reg && (tdr_auto || (wr_tdrs && reg_wdata[`PLPB_TDRS_START]));
  wire [2:0] tdr_room = tdr_cross_reg ? `PLPB_TDR_CROSS_SLOTS : `PLPB_TDR_SLOTS;
  wire new_cross = tdr_busy_reg && tdr_refl_valid && tdr_refl_cross && !tdr_cross_reg;
  wire store_refl = tdr_busy_reg && tdr_refl_valid && !tdr_refl_cross
                    && (tdr_cnt_reg < tdr_room);

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      link_d_reg <= 1'b0;
      tdr_start <= 1'b0;
      tdr_busy_reg <= 1'b0;
    end else begin
      link_d_reg <= link_up;
      tdr_start <= tdr_go;
      if (tdr_go) tdr_busy_reg <= 1'b1;
      else if (tdr_done) tdr_busy_reg <= 1'b0;
    end
  end

  // Earliest entries are kept; later ones past the room are dropped
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      tdr_cnt_reg <= '0;
      tdr_cross_reg <= 1'b0;
      tdr_cross_loc_reg <= '0;
    end else if (tdr_go) begin
      tdr_cnt_reg <= '0;
      tdr_cross_reg <= 1'b0;
    end else begin
      if (store_refl) tdr_cnt_reg <= tdr_cnt_reg + 3'h1;
      if (new_cross) begin
        tdr_cross_reg <= 1'b1;
        tdr_cross_loc_reg <= tdr_refl_time;
        if (tdr_cnt_reg > `PLPB_TDR_CROSS_SLOTS) tdr_cnt_reg <= `PLPB_TDR_CROSS_SLOTS;
      end
    end
  end

  for (genvar j = 0; j < 5; j++) begin : g_tdr
    always_ff @(posedge core_clk) begin
      if (!reset_n) tdr_time_mem[j] <= '0;
      else if (store_refl && tdr_cnt_reg == 3'(j)) tdr_time_mem[j] <= tdr_refl_time;
    end
  end

  // ----------------------------------------
  // Passive cable length capture
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) alen_reg <= '0;
    else if (alen_valid && link_up) alen_reg <= alen_metric;
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Results stay readable during and after a run
  wire [11:0] tdr_pick = (tdr_sel_reg < 3'h5) ? tdr_time_mem[tdr_sel_reg]
                                              : tdr_cross_loc_reg;
  wire [15:0] stc_rd = {stc_reg[15:11], gen_busy, sync_lost_reg, lock_reg,
                        stc_reg[7:0]} & 16'h47ff;
  wire [15:0] tdrs_rd = {10'h000, tdr_cross_reg, tdr_cnt_reg, tdr_busy_reg, 1'b0};
  wire [15:0] rd_mux = (reg_addr == `PLPB_ADDR_BMC) ? bmc_reg
                     : (reg_addr == `PLPB_ADDR_GC1) ? gc1_reg
                     : (reg_addr == `PLPB_ADDR_STC) ? stc_rd
                     : (reg_addr == `PLPB_ADDR_ERRC) ? errc_reg
                     : (reg_addr == `PLPB_ADDR_PLEN) ? plen_reg
                     : (reg_addr == `PLPB_ADDR_TDRS) ? tdrs_rd
                     : (reg_addr == `PLPB_ADDR_TDRR) ? {1'b0, tdr_sel_reg, tdr_pick}
                     : (reg_addr == `PLPB_ADDR_ALEN) ? {8'h00, alen_reg}
                     : 16'h0000;

  always_ff @(posedge core_clk) begin
    if (!reset_n) reg_rdata <= '0;
    else if (reg_rd) reg_rdata <= rd_mux;
  end

endmodule

// [verification/plpb_mac.sv]
// MAC stand-in that sends random transmit frames.
// Assumes the bench seeds the generator once.
`timescale 1ns/1ps
module plpb_mac (
  input wire logic core_clk,
  output logic mac_tx_en = 1'b0,
  output logic [3:0] mac_txd = 4'h0
);
  // Idle one nibble in four; data keeps moving while idle
  always @(posedge core_clk) begin
    mac_tx_en <= ($urandom % 4) != 0;
    mac_txd <= 4'($urandom);
  end
endmodule

// [verification/plpb_top_asserts.sv]
// Checker of the self-test block, bound to its top module.
// Assumes reads answer one cycle after the strobe.
`timescale 1ns/1ps
module plpb_chk (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic link_up,
  input wire logic link_ok,
  input wire logic tdr_start,
  input wire logic tdr_done,
  input wire logic mac_tx_en,
  input wire logic [3:0] mac_txd,
  input wire logic mac_rx_dv,
  input wire logic [3:0] mac_rxd
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic lb_reg;
  // Shadow of the MAC loop bit, so the checks know the mode
  always_ff @(posedge core_clk)
    if (!reset_n) lb_reg <= 1'b0;
    else if (reg_wr && reg_addr == 5'h00) lb_reg <= reg_wdata[14];
  property p_hold; !$past(reg_rd) |-> $stable(reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_link; $past(reset_n) && $past(reset_n, 2) |->
    link_ok == ($past(link_up) && !$past(lb_reg)); endproperty
  a_link: assert property (p_link) else $error("link report wrong");
  property p_mdv; lb_reg && $past(lb_reg) |-> mac_rx_dv == $past(mac_tx_en); endproperty
  a_mdv: assert property (p_mdv) else $error("loop valid wrong");
  property p_md; lb_reg && $past(lb_reg) && mac_rx_dv |-> mac_rxd == $past(mac_txd); endproperty
  a_md: assert property (p_md) else $error("loop data wrong");
  property p_one; tdr_start |=> !tdr_start; endproperty
  a_one: assert property (p_one) else $error("start too long");
  property p_cause; tdr_start |-> $past(reg_wr && reg_addr == 5'h1d && reg_wdata[0])
    || !$past(link_up) || !$past(link_up, 2); endproperty
  a_cause: assert property (p_cause) else $error("start without cause");
  property p_busy; tdr_start ##1 (!tdr_done) [*6] |=> !tdr_start; endproperty
  a_busy: assert property (p_busy) else $error("start while busy");
  property p_quiet; !$past(reset_n) |-> !link_ok && !tdr_start && reg_rdata == 16'h0000;
  endproperty
  a_quiet: assert property (p_quiet) else $error("output after reset");
  c_loop: cover property (lb_reg && mac_rx_dv);
  c_tdr: cover property (tdr_start && link_up);
  c_auto: cover property (tdr_start && !link_up);
endmodule
bind plpb_top plpb_chk u_chk (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .link_up, .link_ok, .tdr_start, .tdr_done, .mac_tx_en, .mac_txd, .mac_rx_dv,
  .mac_rxd);

// [verification/tb.sv]
// Bench: registers, MAC loop, reflectometry runs, length capture.
// Assumes the checker binds itself to the design.
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, link_up = 1'b1;
  logic tdr_done = 1'b0, tdr_refl_valid = 1'b0, alen_valid = 1'b0, line_rx_dv = 1'b0, quiet = 1'b0;
  logic line_tx_ready = 1'b0, mac_tx_en, link_ok, mac_tx_ready, mac_rx_dv, line_tx_en, tdr_start;
  logic [3:0] line_rxd = 4'h0, mac_txd, mac_rxd, line_txd;
  logic [4:0] reg_addr = 5'h00;
  logic [7:0] alen_metric = 8'h00;
  logic [11:0] tdr_refl_time = 12'h000, tm[5];
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, v;
  int fails = 0, comparisons = 0, cyc = 0;
  plpb_top uut (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .speed_100(1'b1), .rmii_mode(1'b0), .aneg_on(1'b0), .link_up, .link_ok,
    .mac_tx_en, .mac_txd, .mac_tx_ready, .mac_rx_dv, .mac_rxd, .line_rx_dv, .line_rxd,
    .line_tx_en, .line_txd, .line_tx_ready, .tdr_start, .tdr_done, .tdr_refl_valid,
    .tdr_refl_cross(1'b0), .tdr_refl_time, .alen_valid, .alen_metric);
  plpb_mac mac (.core_clk, .mac_tx_en, .mac_txd);
  always #2.5 core_clk = ~core_clk;
  // Random line traffic and sink stalls; a ceiling cuts a hang short
  always @(posedge core_clk) begin
    line_rx_dv <= 1'($urandom) && !quiet;
    line_rxd <= 4'($urandom);
    line_tx_ready <= 1'($urandom);
    cyc++;
    if (cyc == 5000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, s);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Writes leave a spare edge so strobes never toggle twice at once
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk) reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rc(input string nm, input logic [4:0] a, input logic [15:0] m, e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk) reg_rd <= 1'b0;
    @(posedge core_clk) chk(nm, e & m, reg_rdata & m);
  endtask
  // Expected reflection readback: select echoed, then the stored time
  function automatic logic [15:0] tdr_word(input int i);
    return {1'b0, 3'(i), tm[i]};
  endfunction
  task automatic wrap_up();
    $display("Counts: comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    void'($urandom(18));
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    rc("bmc", 5'h00, 16'hffff, 16'h0000);
    rc("stc", 5'h16, 16'h707f, 16'h0000);
    rc("plen", 5'h1c, 16'h07ff, 16'h0040);
    rc("hole", 5'h05, 16'hffff, 16'h0000);
    v = 16'($urandom);
    wr(5'h1c, v);
    rc("plen", 5'h1c, 16'h07ff, v);
    wr(5'h09, 16'h0100);
    $display("test registers done");
    wr(5'h00, 16'h4000);
    repeat (64) @(posedge core_clk);
    chk("link_ok", 16'h0000, 16'(link_ok));
    wr(5'h00, 16'h0000);
    @(posedge core_clk);
    chk("link_ok", 16'h0001, 16'(link_ok));
    $display("test mac loop done");
    quiet <= 1'b1;
    wr(5'h1d, 16'h0001);
    chk("tdr_start", 16'h0001, 16'(tdr_start));
    for (int i = 0; i < 7; i++) begin
      tdr_refl_valid <= 1'b1;
      tdr_refl_time <= 12'($urandom);
      @(posedge core_clk) tdr_refl_valid <= 1'b0;
      if (i < 5) tm[i] = tdr_refl_time;
      @(posedge core_clk);
    end
    tdr_done <= 1'b1;
    @(posedge core_clk) tdr_done <= 1'b0;
    rc("tdr_count", 5'h1d, 16'h001e, 16'h0014);
    for (int i = 0; i < 5; i++) begin
      wr(5'h1e, 16'(i));
      rc("tdr_time", 5'h1e, 16'h7fff, tdr_word(i));
    end
    $display("test reflectometry done");
    alen_metric <= 8'($urandom);
    alen_valid <= 1'b1;
    @(posedge core_clk) alen_valid <= 1'b0;
    v = 16'(alen_metric);
    link_up <= 1'b0;
    alen_metric <= ~alen_metric;
    @(posedge core_clk) alen_valid <= 1'b1;
    @(posedge core_clk) alen_valid <= 1'b0;
    for (int i = 0; i < 8 && tdr_start !== 1'b1; i++) @(posedge core_clk);
    chk("tdr_auto", 16'h0001, 16'(tdr_start));
    tdr_done <= 1'b1;
    @(posedge core_clk) tdr_done <= 1'b0;
    rc("alen", 5'h1f, 16'h00ff, v);
    $display("test link loss done");
    // Generator looped at the coding input: checker must lock with no bad bytes
    wr(5'h1c, 16'h0010);
    wr(5'h16, 16'h0021);
    repeat (1500) @(posedge core_clk);
    rc("stc_lock", 5'h16, 16'h033f, 16'h0121);
    rc("errc", 5'h1b, 16'hffff, 16'h0000);
    chk("line_tx_en", 16'h0000, 16'(line_tx_en));
    $display("test prbs loop done");
    wrap_up();
  end
endmodule
